// [hw/ack_button_restart_teach_ctrl.sv]
// acknowledgement button, manual gating restart and fixed-blanking teach control
`timescale 1ns/10ps
`default_nettype none
`include "ack_teach_consts.svh"
module ack_button_restart_teach_ctrl #(
  parameter int BEAMS = 16,
  parameter int MS_DIV = `MS_DIV,
  parameter int SHORT_MS = `SHORT_MS,
  parameter int TEACH_WIN_MS = `TEACH_WIN_MS
) (
  input  wire logic             core_clk_in,
  input  wire logic             reset_n_in,
  input  wire logic             ack_button_in,
  input  wire logic             teach_key_in,
  input  wire logic             gating_start_in,
  input  wire logic             field_clear_in,
  input  wire logic [BEAMS-1:0] beams_blocked_in,
  input  wire logic             gating_error_in,
  input  wire logic             gating_valid_in,
  input  wire logic             gating_safety_switch_output_req_in,
  output logic                  safety_switch_output_out,
  output logic                  red_led_out,
  output logic                  yellow_led_out,
  output logic                  lockout_out,
  output logic                  process_gating_force_out,
  output logic                  process_gating_resume_out,
  output logic                  gating_signal_output_out,
  output logic [BEAMS-1:0]      blanking_mask_out,
  output logic                  blanking_enable_out
);
  import ack_teach_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0]         ack_sync;
    logic [1:0]         teach_sync;
    logic [1:0]         cs_sync;
    logic [1:0]         clr_sync;
    logic [1:0]         err_sync;
    logic [1:0]         val_sync;
    logic [1:0]         req_sync;
    logic [16:0]        div;
    logic               tick;
    logic [7:0]         ack_deb_cnt;
    logic               ack_deb;
    logic               ack_last;
    logic [7:0]         key_deb_cnt;
    logic               key_deb;
    logic               key_last;
    logic [`MS_W-1:0]   press_ms;
    logic [`MS_W-1:0]   gap_ms;
    logic               gate_err;
    ack_state_t         ast;
    teach_state_t       tst;
    logic [`MS_W-1:0]   teach_ms;
    logic [9:0]         tog_ms;
    logic               safety_switch_output;
    logic               red;
    logic               yellow;
    logic               lockout;
    logic               forced;
    logic               resume;
    logic               sig;
    logic [BEAMS-1:0]   mask;
    logic [BEAMS-1:0]   cand;
    logic               blank_en;
  } ctrl_t;

  ctrl_t s_q;
  ctrl_t s_d;

  logic ack_rise;
  logic ack_fall;
  logic key_rise;
  logic key_fall;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    // pins other than reset_n_in and beams_blocked_in pass two flops before anything else looks at them
    s_d.ack_sync   = {s_q.ack_sync[0], ack_button_in};
    s_d.teach_sync = {s_q.teach_sync[0], teach_key_in};
    s_d.cs_sync    = {s_q.cs_sync[0], gating_start_in};
    s_d.clr_sync   = {s_q.clr_sync[0], field_clear_in};
    s_d.err_sync   = {s_q.err_sync[0], gating_error_in};
    s_d.val_sync   = {s_q.val_sync[0], gating_valid_in};
    s_d.req_sync   = {s_q.req_sync[0], gating_safety_switch_output_req_in};
    // edges come from registered copies so next-state logic never reads itself
    s_d.ack_last   = s_q.ack_deb;
    s_d.key_last   = s_q.key_deb;

    // millisecond tick from the system clock
    s_d.tick = 1'b0;
    if (s_q.div == 17'(MS_DIV - 1)) begin
      s_d.div  = 17'h0;
      s_d.tick = 1'b1;
    end else begin
      s_d.div = s_q.div + 17'h1;
    end

    // debounce: input must differ for the whole window before it is taken
    if (s_q.tick) begin
      if (s_q.ack_sync[1] == s_q.ack_deb) begin
        s_d.ack_deb_cnt = 8'h0;
      end else if (s_q.ack_deb_cnt == 8'(`DEB_MS - 1)) begin
        s_d.ack_deb_cnt = 8'h0;
        s_d.ack_deb     = s_q.ack_sync[1];
      end else begin
        s_d.ack_deb_cnt = s_q.ack_deb_cnt + 8'h1;
      end
      if (s_q.teach_sync[1] == s_q.key_deb) begin
        s_d.key_deb_cnt = 8'h0;
      end else if (s_q.key_deb_cnt == 8'(`DEB_MS - 1)) begin
        s_d.key_deb_cnt = 8'h0;
        s_d.key_deb     = s_q.teach_sync[1];
      end else begin
        s_d.key_deb_cnt = s_q.key_deb_cnt + 8'h1;
      end
    end

    // press length, saturating so a stuck button cannot wrap
    if (ack_rise) begin
      s_d.press_ms = '0;
    end else if (s_q.ack_deb && s_q.tick && s_q.press_ms != '1) begin
      s_d.press_ms = s_q.press_ms + `MS_W'(1);
    end
    if (ack_fall) begin
      s_d.gap_ms = '0;
    end else if (!s_q.ack_deb && s_q.tick && s_q.gap_ms != '1) begin
      s_d.gap_ms = s_q.gap_ms + `MS_W'(1);
    end

    // gating error is sticky until a restart clears it; set wins
    if (s_q.err_sync[1]) begin
      s_d.gate_err = 1'b1;
    end

    // ----- restart interlock
    case (s_q.ast)
      ST_LOCKED: begin
        if (s_q.ack_deb && s_q.press_ms >= `MS_W'(SHORT_MS)) begin
          s_d.ast = ST_LOCKOUT;
        end else if (ack_fall && s_q.gate_err && s_q.cs_sync[1]
                     && s_q.press_ms < `MS_W'(`PRESS_MAX_MS)) begin
          s_d.ast = ST_GAP;
        end else if (ack_fall && s_q.press_ms >= `MS_W'(`PRESS_MIN_MS)
                     && s_q.press_ms < `MS_W'(`PRESS_MAX_MS)
                     && s_q.clr_sync[1]) begin
          s_d.ast = ST_ON;
        end
      end
      ST_GAP: begin
        if (!s_q.cs_sync[1] || s_q.gap_ms >= `MS_W'(`GAP_MAX_MS)) begin
          s_d.ast = ST_LOCKED;
        end else if (ack_rise) begin
          s_d.gate_err = s_q.err_sync[1]; // a fresh error wins over the clear
          s_d.tog_ms   = 10'h0;
          if (s_q.val_sync[1] && !s_q.clr_sync[1]) begin
            s_d.resume = 1'b1;
            s_d.ast    = ST_LOCKED;
          end else begin
            s_d.ast = ST_FORCE;
          end
        end
      end
      ST_FORCE: begin
        if (!s_q.ack_deb || !s_q.cs_sync[1]) begin
          s_d.ast = ST_LOCKED;
        end else if (s_q.press_ms >= `MS_W'(SHORT_MS)) begin
          s_d.ast = ST_LOCKOUT;
        end
      end
      ST_ON: begin
        if (!s_q.clr_sync[1] && !s_q.req_sync[1]) begin
          s_d.ast = ST_LOCKED;
        end
      end
      ST_LOCKOUT: begin
        s_d.ast = ST_LOCKOUT; // only a reset, or a pending resume meeting req_sync, leaves lockout
      end
      default: begin
        s_d.ast = ST_LOCKED;
      end
    endcase

    // resume request ends once the running sequence drives the outputs
    if (s_q.resume && s_q.req_sync[1]) begin
      s_d.resume = 1'b0;
      s_d.ast    = ST_ON;
    end

    s_d.forced  = (s_d.ast == ST_FORCE);
    s_d.safety_switch_output    = (s_d.ast == ST_ON) || (s_d.ast == ST_FORCE);
    s_d.lockout = (s_d.ast == ST_LOCKOUT);
    s_d.red     = !s_d.safety_switch_output;
    s_d.yellow  = (s_d.ast == ST_LOCKED) && s_q.clr_sync[1];

    // signal output blinks while a manual restart waits for the outputs
    // blinking stops as soon as the outputs are on, forced or not
    if ((s_q.ast == ST_FORCE || s_q.resume) && !s_q.safety_switch_output && !s_q.req_sync[1]) begin
      if (s_q.tick) begin
        if (s_q.tog_ms == 10'(`TOGGLE_MS - 1)) begin
          s_d.tog_ms = 10'h0;
          s_d.sig    = !s_q.sig;
        end else begin
          s_d.tog_ms = s_q.tog_ms + 10'h1;
        end
      end
    end else begin
      s_d.sig = 1'b0;
    end

    // ----- fixed-blanking teach
    if (s_q.tick && s_q.teach_ms != '1) begin
      s_d.teach_ms = s_q.teach_ms + `MS_W'(1);
    end
    case (s_q.tst)
      TE_IDLE: begin
        if (key_rise) begin
          s_d.tst = TE_ARMED;
        end
      end
      TE_ARMED: begin
        if (key_fall) begin
          s_d.tst      = TE_RUN;
          s_d.teach_ms = '0;
          s_d.cand     = beams_blocked_in;
        end
      end
      TE_RUN: begin
        if (s_q.teach_ms >= `MS_W'(TEACH_WIN_MS)) begin
          s_d.tst = TE_IDLE;
        end else if (key_rise) begin
          s_d.tst = TE_ACC;
        end
      end
      TE_ACC: begin
        if (s_q.teach_ms >= `MS_W'(TEACH_WIN_MS)) begin
          s_d.tst = TE_IDLE;
        end else if (key_fall) begin
          s_d.tst      = TE_IDLE;
          s_d.mask     = s_q.cand;
          s_d.blank_en = |s_q.cand;
        end
      end
      default: begin
        s_d.tst = TE_IDLE;
      end
    endcase
  end

  assign ack_rise = s_q.ack_deb && !s_q.ack_last;
  assign ack_fall = !s_q.ack_deb && s_q.ack_last;
  assign key_rise = s_q.key_deb && !s_q.key_last;
  assign key_fall = !s_q.key_deb && s_q.key_last;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      s_q        <= '0;
      s_q.ast    <= ST_LOCKED;
      s_q.tst    <= TE_IDLE;
      s_q.red    <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign safety_switch_output_out  = s_q.safety_switch_output;
  assign red_led_out               = s_q.red;
  assign yellow_led_out            = s_q.yellow;
  assign lockout_out               = s_q.lockout;
  assign process_gating_force_out  = s_q.forced;
  assign process_gating_resume_out = s_q.resume;
  assign gating_signal_output_out  = s_q.sig;
  assign blanking_mask_out         = s_q.mask;
  assign blanking_enable_out       = s_q.blank_en;
endmodule : ack_button_restart_teach_ctrl
`default_nettype wire

// [hw/ack_teach_consts.svh]
// constants for the acknowledgement button and teach controller
`ifndef ACK_TEACH_CONSTS_SVH
`define ACK_TEACH_CONSTS_SVH
`define CLK_HZ          20000000
`define MS_DIV          (`CLK_HZ / 1000)
`define DEB_MS          10
`define PRESS_MIN_MS    150
`define PRESS_MAX_MS    4000
`define SHORT_MS        30000
`define TEACH_WIN_MS    60000
`define GAP_MAX_MS      4000
`define TOGGLE_MS       500
`define MS_W            17
`endif

// [hw/ack_teach_pkg.sv]
// types for the acknowledgement button and teach controller
package ack_teach_pkg;
  typedef enum logic [2:0] {
    ST_LOCKED  = 3'b000,
    ST_ON      = 3'b001,
    ST_LOCKOUT = 3'b010,
    ST_GAP     = 3'b011,
    ST_FORCE   = 3'b100
  } ack_state_t;

  typedef enum logic [1:0] {
    TE_IDLE  = 2'b00,
    TE_ARMED = 2'b01,
    TE_RUN   = 2'b10,
    TE_ACC   = 2'b11
  } teach_state_t;
endpackage : ack_teach_pkg

// [tb/ack_teach_chk.sv]
// assertion checker for the acknowledgement button and teach controller
`timescale 1ns/10ps
`default_nettype none
module ack_teach_chk #(
  parameter int BEAMS = 16
) (
  input wire logic             core_clk_in,
  input wire logic             reset_n_in,
  input wire logic             ack_button_in,
  input wire logic             teach_key_in,
  input wire logic             gating_start_in,
  input wire logic             field_clear_in,
  input wire logic [BEAMS-1:0] beams_blocked_in,
  input wire logic             gating_error_in,
  input wire logic             gating_valid_in,
  input wire logic             gating_safety_switch_output_req_in,
  input wire logic             safety_switch_output_out,
  input wire logic             red_led_out,
  input wire logic             yellow_led_out,
  input wire logic             lockout_out,
  input wire logic             process_gating_force_out,
  input wire logic             process_gating_resume_out,
  input wire logic             gating_signal_output_out,
  input wire logic [BEAMS-1:0] blanking_mask_out,
  input wire logic             blanking_enable_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!reset_n_in);
  // ----------
  // properties
  // ----------
  a_reset_state: assert property (disable iff (1'b0) !reset_n_in |=> red_led_out)
    else $error("red indicator off after reset");
  a_red_tracks_off: assert property (red_led_out == !safety_switch_output_out)
    else $error("red indicator disagrees with outputs");
  a_yellow_when_locked: assert property (yellow_led_out |-> red_led_out)
    else $error("yellow indicator while outputs on");
  a_unlock_after_release: assert property (($rose(safety_switch_output_out)
    && !process_gating_force_out && !gating_safety_switch_output_req_in && !$past(gating_safety_switch_output_req_in))
    |-> !$past(ack_button_in, 3))
    else $error("outputs on while button still held");
  a_lockout_stays: assert property (lockout_out |=> lockout_out)
    else $error("lockout left without reset");
  a_lockout_cause: assert property ($rose(lockout_out) |-> $past(ack_button_in, 3))
    else $error("lockout without held button");
  a_lockout_off: assert property (lockout_out ##1 lockout_out |-> !safety_switch_output_out)
    else $error("outputs on during lockout");
  a_force_drives: assert property (process_gating_force_out |-> ##[0:4] safety_switch_output_out)
    else $error("forced gating without outputs on");
  a_force_or_resume: assert property (!(process_gating_force_out && process_gating_resume_out))
    else $error("force and resume together");
  a_signal_quiet: assert property (safety_switch_output_out [*2] |-> !gating_signal_output_out)
    else $error("signal output toggling with outputs on");
  a_blank_flag: assert property ($stable(blanking_mask_out)
    |-> blanking_enable_out == (|blanking_mask_out))
    else $error("blanking enable disagrees with mask");
  a_mask_on_release: assert property ($changed(blanking_mask_out) |-> !$past(teach_key_in, 3))
    else $error("mask changed while key held");
  c_unlock: cover property ($rose(safety_switch_output_out));
  c_force: cover property ($rose(process_gating_force_out));
  c_resume: cover property ($rose(process_gating_resume_out));
  c_blank: cover property ($rose(blanking_enable_out));
endmodule : ack_teach_chk
bind ack_button_restart_teach_ctrl ack_teach_chk #(.BEAMS(BEAMS)) chk (.core_clk_in, .reset_n_in,
  .ack_button_in, .teach_key_in, .gating_start_in, .field_clear_in, .beams_blocked_in,
  .gating_error_in, .gating_valid_in, .gating_safety_switch_output_req_in, .safety_switch_output_out,
  .red_led_out, .yellow_led_out, .lockout_out, .process_gating_force_out,
  .process_gating_resume_out, .gating_signal_output_out, .blanking_mask_out,
  .blanking_enable_out);
`default_nettype wire

// [tb/operator_model.sv]
// behavioural operator: acknowledgement pushbutton and teach key switch
`timescale 1ns/10ps
`default_nettype none
module operator_model (
  input  wire logic core_clk_in,
  output logic      ack_button_out,
  output logic      teach_key_out
);
  // released contacts read low through the input pull-down
  initial begin
    ack_button_out = 1'b0;
    teach_key_out  = 1'b0;
  end
  // lines move only at the falling edge so the sampling edge never races
  task automatic set_line(input bit key, input bit level);
    @(negedge core_clk_in);
    if (key) teach_key_out = level;
    else ack_button_out = level;
  endtask : set_line
endmodule : operator_model
`default_nettype wire

// [tb/tb.sv]
// self-checking testbench for the acknowledgement button and teach controller
`timescale 1ns/10ps
`default_nettype none
module tb;
  localparam int MSD = 4;
  logic clk, rst_n, btn, key, cs, clr, gerr, gval, greq, safety_switch_output, red, yel, lko, frc, rsm, sig, ben;
  logic [15:0] beams, mask;
  int err_total, samples_checked, cyc, seen;
  // short ms tick and short lockout/teach windows keep the run small
  ack_button_restart_teach_ctrl #(.BEAMS(16), .MS_DIV(MSD), .SHORT_MS(5000),
    .TEACH_WIN_MS(100)) dut (.core_clk_in(clk), .reset_n_in(rst_n), .ack_button_in(btn),
    .teach_key_in(key), .gating_start_in(cs), .field_clear_in(clr), .beams_blocked_in(beams),
    .gating_error_in(gerr), .gating_valid_in(gval), .gating_safety_switch_output_req_in(greq),
    .safety_switch_output_out(safety_switch_output), .red_led_out(red), .yellow_led_out(yel),
    .lockout_out(lko), .process_gating_force_out(frc), .process_gating_resume_out(rsm),
    .gating_signal_output_out(sig), .blanking_mask_out(mask), .blanking_enable_out(ben));
  operator_model op (.core_clk_in(clk), .ack_button_out(btn), .teach_key_out(key));
  // -------
  // helpers
  // -------
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic test_done;
    if (err_total == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : test_done
  always @(posedge clk) begin
    cyc++;
    if (cyc == 90000) begin
      err_total++;
      test_done();
    end
  end
  task automatic check(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t seen %b expected %b", $time, got, exp);
    end
  endtask : check
  task automatic ms(input int n);
    repeat (n * MSD) @(negedge clk);
  endtask : ms
  task automatic tap(input bit k, input int h, input int r);
    op.set_line(k, 1'b1);
    ms(h);
    op.set_line(k, 1'b0);
    ms(r);
  endtask : tap
  task automatic do_reset;
    rst_n = 1'b0;
    repeat (10) @(negedge clk);
    check(red, 1'b1);
    check(lko, 1'b0);
    rst_n = 1'b1;
    ms(20);
  endtask : do_reset
  task automatic fault;
    gerr = 1'b1;
    @(negedge clk);
    gerr = 1'b0;
  endtask : fault
  // ---------
  // scenarios
  // ---------
  task automatic t_unlock;
    clr = 1'b1;
    ms(20);
    check(yel, 1'b1);
    tap(0, 50, 20);
    check(safety_switch_output, 1'b0);
    tap(0, 4100, 20);
    check(safety_switch_output, 1'b0);
    tap(0, 200, 20);
    check(safety_switch_output, 1'b1);
    check(red, 1'b0);
    check(yel, 1'b0);
    clr = 1'b0;
    ms(20);
    check(red, 1'b1);
  endtask : t_unlock
  task automatic t_lockout;
    clr = 1'b1;
    tap(0, 5100, 20);
    check(lko, 1'b1);
    tap(0, 200, 20);
    check(safety_switch_output, 1'b0);
    do_reset();
  endtask : t_lockout
  task automatic t_teach;
    beams = 16'h00f0;
    tap(1, 50, 20);
    tap(1, 50, 20);
    check(mask === 16'h00f0, 1'b1);
    check(ben, 1'b1);
    beams = 16'h0f00;
    tap(1, 50, 20);
    tap(1, 50, 20);
    check(mask === 16'h0f00, 1'b1);
    beams = 16'h0000;
    tap(1, 50, 150);
    check(mask === 16'h0f00, 1'b1);
    tap(1, 50, 20);
    tap(1, 50, 20);
    check(ben, 1'b0);
  endtask : t_teach
  task automatic t_manual(input bit start, input bit valid);
    do_reset();
    clr = 1'b0;
    cs = start;
    gval = valid;
    fault();
    tap(0, 200, 100);
    op.set_line(0, 1'b1);
    ms(20);
    check(frc, start & !valid);
    check(rsm, start & valid);
    seen = 0;
    repeat (1100 * MSD) @(negedge clk) if (sig === 1'b1) seen = 1;
    check(seen != 0, valid);
    op.set_line(0, 1'b0);
    ms(20);
    check(frc, 1'b0);
    greq = valid;
    ms(5);
    check(safety_switch_output, valid);
    ms(600);
    check(sig, 1'b0);
    greq = 1'b0;
  endtask : t_manual
  initial begin
    {rst_n, cs, clr, gerr, gval, greq} = '0;
    beams = 16'h0000;
    do_reset();
    t_unlock();
    t_lockout();
    t_teach();
    t_manual(0, 0);
    t_manual(1, 0);
    t_manual(1, 1);
    test_done();
  end
endmodule : tb
`default_nettype wire
